// [core/cpc_regs.v]
// Chosen here: the APB register port.
`default_nettype none
`include "cpc_defines.vh"

module cpc_regs #(
	parameter [15:0] DEVICE_ID = 16'h0A5C  // arbitrary value
) (
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// analogue bias level, oversampling and power enables
	output reg  [2:0]  mic_bias_level_sel,
	output reg         adc_high_oversample,
	output reg         left_input_amp_en,
	output reg         right_input_amp_en,
	output reg         left_headphone_en,
	output reg         right_headphone_en,
	output reg         left_lineout_en,
	output reg         right_lineout_en,
	output reg         left_dac_en,
	output reg         right_dac_en,
	output reg         left_adc_en,
	output reg         right_adc_en,
	// system clock control
	output reg         system_clock_source,
	output reg         master_clk_invert,
	output reg         master_clk_halve,
	output reg         system_clock_gate,
	output reg  [10:0] system_clock_to_fs_ratio,
	output reg         ratio_code_valid,
	output reg  [2:0]  sample_rate_code,
	output reg         sample_rate_valid,
	// timeout and auxiliary clocks
	output reg  [3:0]  timeout_clk_log2_scale,
	output reg         timeout_clock_en,
	output reg         processing_clock_en,
	output reg         pin_output_clock_en
);

	// analogue field storage
	reg [2:0]  micb_reg;
	reg        osr_reg;
	reg [1:0]  inpwr_reg;
	reg [1:0]  hppwr_reg;
	reg [1:0]  lopwr_reg;
	reg [1:0]  dacpwr_reg;
	reg [1:0]  adcpwr_reg;

	// clock field storage
	reg        div16_reg;
	reg        x4_reg;
	reg        mdiv_reg;
	reg [3:0]  ratio_reg;
	reg [2:0]  sr_reg;
	reg        inv_reg;
	reg        src_reg;
	reg        tohalf_reg;
	reg        opclk_reg;
	reg        sysena_reg;
	reg        dsp_reg;
	reg        toena_reg;

	reg [31:0] rd_word;
	wire [5:0] idx;
	wire       setup_phase;
	wire       wr_take;
	wire [10:0] ratio_dec;
	wire       ratio_ok;
	wire       sr_ok;
	wire [2:0] bias_dec;
	wire [3:0] shift_dec;

	// address map
	function is_mapped;
		input [5:0] i;
		begin
			case (i)
				`CPC_IDX_RESET,
				`CPC_IDX_MICB,
				`CPC_IDX_ADC,
				`CPC_IDX_INPWR,
				`CPC_IDX_HPPWR,
				`CPC_IDX_LOPWR,
				`CPC_IDX_CVPWR,
				`CPC_IDX_CLKA,
				`CPC_IDX_CLKB,
				`CPC_IDX_CLKC: is_mapped = 1'b1;
				default: is_mapped = 1'b0;
			endcase
		end
	endfunction

	assign idx = paddr[7:2];
	assign setup_phase = psel & ~penable;
	// write lands at the access edge with pready high
	assign wr_take = psel & penable & pwrite & pready & is_mapped(idx);

	// read data composition, unused bits zero
	always @* begin
		rd_word = 32'h0000_0000;
		case (idx)
			`CPC_IDX_RESET: rd_word[15:0] = DEVICE_ID;
			`CPC_IDX_MICB:
				rd_word[`CPC_MICB_MSB:`CPC_MICB_LSB] = micb_reg;
			`CPC_IDX_ADC: rd_word[`CPC_OSR_BIT] = osr_reg;
			`CPC_IDX_INPWR: rd_word[1:0] = inpwr_reg;
			`CPC_IDX_HPPWR: rd_word[1:0] = hppwr_reg;
			`CPC_IDX_LOPWR: rd_word[1:0] = lopwr_reg;
			`CPC_IDX_CVPWR: begin
				rd_word[`CPC_DACL_BIT] = dacpwr_reg[1];
				rd_word[`CPC_DACR_BIT] = dacpwr_reg[0];
				rd_word[`CPC_ADCL_BIT] = adcpwr_reg[1];
				rd_word[`CPC_ADCR_BIT] = adcpwr_reg[0];
			end
			`CPC_IDX_CLKA: begin
				rd_word[`CPC_DIV16_BIT] = div16_reg;
				rd_word[`CPC_X4_BIT] = x4_reg;
				rd_word[`CPC_MDIV_BIT] = mdiv_reg;
			end
			`CPC_IDX_CLKB: begin
				rd_word[`CPC_RATIO_MSB:`CPC_RATIO_LSB] = ratio_reg;
				rd_word[`CPC_SR_MSB:`CPC_SR_LSB] = sr_reg;
			end
			`CPC_IDX_CLKC: begin
				rd_word[`CPC_INV_BIT] = inv_reg;
				rd_word[`CPC_SRC_BIT] = src_reg;
				rd_word[`CPC_TOHALF_BIT] = tohalf_reg;
				rd_word[`CPC_OPCLK_BIT] = opclk_reg;
				rd_word[`CPC_SYSENA_BIT] = sysena_reg;
				rd_word[`CPC_DSP_BIT] = dsp_reg;
				rd_word[`CPC_TOENA_BIT] = toena_reg;
			end
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// field flops, defaults on hardware or software reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			micb_reg   <= `CPC_RST_MICB;
			osr_reg    <= `CPC_RST_OSR;
			inpwr_reg  <= `CPC_RST_PAIR;
			hppwr_reg  <= `CPC_RST_PAIR;
			lopwr_reg  <= `CPC_RST_PAIR;
			dacpwr_reg <= `CPC_RST_PAIR;
			adcpwr_reg <= `CPC_RST_PAIR;
			div16_reg  <= `CPC_RST_BIT;
			x4_reg     <= `CPC_RST_BIT;
			mdiv_reg   <= `CPC_RST_BIT;
			ratio_reg  <= `CPC_RST_RATIO;
			sr_reg     <= `CPC_RST_SR;
			inv_reg    <= `CPC_RST_BIT;
			src_reg    <= `CPC_RST_BIT;
			tohalf_reg <= `CPC_RST_BIT;
			opclk_reg  <= `CPC_RST_BIT;
			sysena_reg <= `CPC_RST_BIT;
			dsp_reg    <= `CPC_RST_BIT;
			toena_reg  <= `CPC_RST_BIT;
		end else if (wr_take) begin
			case (idx)
				// software reset restores every field
				`CPC_IDX_RESET: begin
					micb_reg   <= `CPC_RST_MICB;
					osr_reg    <= `CPC_RST_OSR;
					inpwr_reg  <= `CPC_RST_PAIR;
					hppwr_reg  <= `CPC_RST_PAIR;
					lopwr_reg  <= `CPC_RST_PAIR;
					dacpwr_reg <= `CPC_RST_PAIR;
					adcpwr_reg <= `CPC_RST_PAIR;
					div16_reg  <= `CPC_RST_BIT;
					x4_reg     <= `CPC_RST_BIT;
					mdiv_reg   <= `CPC_RST_BIT;
					ratio_reg  <= `CPC_RST_RATIO;
					sr_reg     <= `CPC_RST_SR;
					inv_reg    <= `CPC_RST_BIT;
					src_reg    <= `CPC_RST_BIT;
					tohalf_reg <= `CPC_RST_BIT;
					opclk_reg  <= `CPC_RST_BIT;
					sysena_reg <= `CPC_RST_BIT;
					dsp_reg    <= `CPC_RST_BIT;
					toena_reg  <= `CPC_RST_BIT;
				end
				`CPC_IDX_MICB:
					micb_reg <= pwdata[`CPC_MICB_MSB:`CPC_MICB_LSB];
				`CPC_IDX_ADC:
					osr_reg <= pwdata[`CPC_OSR_BIT];
				`CPC_IDX_INPWR: begin
					inpwr_reg[1] <= pwdata[`CPC_LEFT_BIT];
					inpwr_reg[0] <= pwdata[`CPC_RIGHT_BIT];
				end
				`CPC_IDX_HPPWR: begin
					hppwr_reg[1] <= pwdata[`CPC_LEFT_BIT];
					hppwr_reg[0] <= pwdata[`CPC_RIGHT_BIT];
				end
				`CPC_IDX_LOPWR: begin
					lopwr_reg[1] <= pwdata[`CPC_LEFT_BIT];
					lopwr_reg[0] <= pwdata[`CPC_RIGHT_BIT];
				end
				`CPC_IDX_CVPWR: begin
					dacpwr_reg[1] <= pwdata[`CPC_DACL_BIT];
					dacpwr_reg[0] <= pwdata[`CPC_DACR_BIT];
					adcpwr_reg[1] <= pwdata[`CPC_ADCL_BIT];
					adcpwr_reg[0] <= pwdata[`CPC_ADCR_BIT];
				end
				`CPC_IDX_CLKA: begin
					div16_reg <= pwdata[`CPC_DIV16_BIT];
					x4_reg    <= pwdata[`CPC_X4_BIT];
					mdiv_reg  <= pwdata[`CPC_MDIV_BIT];
				end
				`CPC_IDX_CLKB: begin
					ratio_reg <= pwdata[`CPC_RATIO_MSB:`CPC_RATIO_LSB];
					sr_reg    <= pwdata[`CPC_SR_MSB:`CPC_SR_LSB];
				end
				`CPC_IDX_CLKC: begin
					inv_reg    <= pwdata[`CPC_INV_BIT];
					src_reg    <= pwdata[`CPC_SRC_BIT];
					tohalf_reg <= pwdata[`CPC_TOHALF_BIT];
					opclk_reg  <= pwdata[`CPC_OPCLK_BIT];
					sysena_reg <= pwdata[`CPC_SYSENA_BIT];
					dsp_reg    <= pwdata[`CPC_DSP_BIT];
					toena_reg  <= pwdata[`CPC_TOENA_BIT];
				end
				default: micb_reg <= micb_reg;
			endcase
		end
	end

	// apb answer, prepared in the setup cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup_phase;
			pslverr <= setup_phase & ~is_mapped(idx);
			if (setup_phase && !pwrite) begin
				prdata <= rd_word;
			end
		end
	end

	// decoders
	cpc_ratio_decode u_ratio (
		.code  (ratio_reg),
		.ratio (ratio_dec),
		.valid (ratio_ok)
	);

	cpc_level_decode u_level (
		.sr_code     (sr_reg),
		.micb_code   (micb_reg),
		.div_sixteen (div16_reg),
		.times_four  (x4_reg),
		.half_bypass (tohalf_reg),
		.sr_valid    (sr_ok),
		.bias_level  (bias_dec),
		.to_shift    (shift_dec)
	);

	// registered outputs, one cycle behind the fields
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mic_bias_level_sel     <= `CPC_RST_MICB;
			adc_high_oversample    <= `CPC_RST_OSR;
			left_input_amp_en      <= `CPC_RST_BIT;
			right_input_amp_en     <= `CPC_RST_BIT;
			left_headphone_en      <= `CPC_RST_BIT;
			right_headphone_en     <= `CPC_RST_BIT;
			left_lineout_en        <= `CPC_RST_BIT;
			right_lineout_en       <= `CPC_RST_BIT;
			left_dac_en            <= `CPC_RST_BIT;
			right_dac_en           <= `CPC_RST_BIT;
			left_adc_en            <= `CPC_RST_BIT;
			right_adc_en           <= `CPC_RST_BIT;
			system_clock_source    <= `CPC_RST_BIT;
			master_clk_invert      <= `CPC_RST_BIT;
			master_clk_halve       <= `CPC_RST_BIT;
			system_clock_gate      <= `CPC_RST_BIT;
			system_clock_to_fs_ratio     <= `CPC_RST_RDEC;
			ratio_code_valid       <= `CPC_RST_VALID;
			sample_rate_code       <= `CPC_RST_SR;
			sample_rate_valid      <= `CPC_RST_VALID;
			timeout_clk_log2_scale <= `CPC_RST_SCALE;
			timeout_clock_en       <= `CPC_RST_BIT;
			processing_clock_en    <= `CPC_RST_BIT;
			pin_output_clock_en    <= `CPC_RST_BIT;
		end else begin
			mic_bias_level_sel     <= bias_dec;
			adc_high_oversample    <= osr_reg;
			left_input_amp_en      <= inpwr_reg[1];
			right_input_amp_en     <= inpwr_reg[0];
			left_headphone_en      <= hppwr_reg[1];
			right_headphone_en     <= hppwr_reg[0];
			left_lineout_en        <= lopwr_reg[1];
			right_lineout_en       <= lopwr_reg[0];
			left_dac_en            <= dacpwr_reg[1];
			right_dac_en           <= dacpwr_reg[0];
			left_adc_en            <= adcpwr_reg[1];
			right_adc_en           <= adcpwr_reg[0];
			system_clock_source    <= src_reg;
			master_clk_invert      <= inv_reg;
			master_clk_halve       <= mdiv_reg;
			system_clock_gate      <= sysena_reg;
			system_clock_to_fs_ratio     <= ratio_dec;
			ratio_code_valid       <= ratio_ok;
			sample_rate_code       <= sr_reg;
			sample_rate_valid      <= sr_ok;
			timeout_clk_log2_scale <= shift_dec;
			timeout_clock_en       <= toena_reg;
			processing_clock_en    <= dsp_reg;
			pin_output_clock_en    <= opclk_reg;
		end
	end

endmodule

`default_nettype wire

// [core/cpc_defines.vh]
`ifndef CPC_DEFINES_VH
`define CPC_DEFINES_VH

// register indexes, byte address is four times the index
`define CPC_IDX_RESET   6'h00
`define CPC_IDX_MICB    6'h07
`define CPC_IDX_ADC     6'h0A
`define CPC_IDX_INPWR   6'h0C
`define CPC_IDX_HPPWR   6'h0E
`define CPC_IDX_LOPWR   6'h0F
`define CPC_IDX_CVPWR   6'h12
`define CPC_IDX_CLKA    6'h14
`define CPC_IDX_CLKB    6'h15
`define CPC_IDX_CLKC    6'h16

// field positions
`define CPC_MICB_LSB    0
`define CPC_MICB_MSB    2
`define CPC_OSR_BIT     0
`define CPC_LEFT_BIT    1
`define CPC_RIGHT_BIT   0
`define CPC_DACL_BIT    3
`define CPC_DACR_BIT    2
`define CPC_ADCL_BIT    1
`define CPC_ADCR_BIT    0
`define CPC_DIV16_BIT   14
`define CPC_X4_BIT      13
`define CPC_MDIV_BIT    0
`define CPC_RATIO_LSB   10
`define CPC_RATIO_MSB   13
`define CPC_SR_LSB      0
`define CPC_SR_MSB      2
`define CPC_INV_BIT     15
`define CPC_SRC_BIT     14
`define CPC_TOHALF_BIT  12
`define CPC_OPCLK_BIT   3
`define CPC_SYSENA_BIT  2
`define CPC_DSP_BIT     1
`define CPC_TOENA_BIT   0

// reset values
`define CPC_RST_MICB    3'h0
`define CPC_RST_OSR     1'h1
`define CPC_RST_PAIR    2'h0
`define CPC_RST_BIT     1'h0
`define CPC_RST_RATIO   4'h3
`define CPC_RST_SR      3'h5
`define CPC_RST_RDEC    11'h100
`define CPC_RST_VALID   1'h1
`define CPC_RST_SCALE   4'hF

// decode limits
`define CPC_RATIO_LAST  4'h9
`define CPC_SR_LAST     3'h5
`define CPC_MICB_TOP    3'h4

`endif

// [core/cpc_ratio_decode.v]
`default_nettype none
`include "cpc_defines.vh"

module cpc_ratio_decode (
	// ratio code
	input  wire [3:0]  code,
	// decoded ratio
	output reg  [10:0] ratio,
	output reg         valid
);

	// system_clock over fs ratio table
	always @* begin
		valid = (code <= `CPC_RATIO_LAST);
		case (code)
			4'h0: ratio = 11'h040;
			4'h1: ratio = 11'h080;
			4'h2: ratio = 11'h0C0;
			4'h3: ratio = 11'h100;
			4'h4: ratio = 11'h180;
			4'h5: ratio = 11'h200;
			4'h6: ratio = 11'h300;
			4'h7: ratio = 11'h400;
			4'h8: ratio = 11'h580;
			4'h9: ratio = 11'h600;
			default: ratio = 11'h000;
		endcase
	end

endmodule

`default_nettype wire

// [core/cpc_level_decode.v]
`default_nettype none
`include "cpc_defines.vh"

module cpc_level_decode (
	// field codes
	input  wire [2:0] sr_code,
	input  wire [2:0] micb_code,
	input  wire       div_sixteen,
	input  wire       times_four,
	input  wire       half_bypass,
	// decoded values
	output reg        sr_valid,
	output reg  [2:0] bias_level,
	output reg  [3:0] to_shift
);

	always @* begin
		// reserved sample rate codes
		sr_valid = (sr_code <= `CPC_SR_LAST);
		// codes above four share the top level
		if (micb_code >= `CPC_MICB_TOP) begin
			bias_level = `CPC_MICB_TOP;
		end else begin
			bias_level = micb_code;
		end
		// log2 of timeout clock scale, two's complement
		to_shift = 4'h0;
		if (times_four) begin
			to_shift = to_shift + 4'h2;
		end
		if (div_sixteen) begin
			to_shift = to_shift - 4'h4;
		end
		if (!half_bypass) begin
			to_shift = to_shift - 4'h1;
		end
	end

endmodule

`default_nettype wire

// [test/cpc_regs_asserts.sv]
`default_nettype none
module cpc_regs_asserts (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// fields
	input wire logic [2:0]  mic_bias_level_sel,
	input wire logic        adc_high_oversample,
	input wire logic        left_dac_en,
	input wire logic        right_dac_en,
	input wire logic        left_adc_en,
	input wire logic        right_adc_en,
	input wire logic [10:0] system_clock_to_fs_ratio,
	input wire logic        ratio_code_valid,
	input wire logic [2:0]  sample_rate_code,
	input wire logic        sample_rate_valid,
	input wire logic [3:0]  timeout_clk_log2_scale,
	input wire logic        pin_output_clock_en
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// access edge of a write or read
	sequence s_wr(logic [5:0] i);
		psel && penable && pready && pwrite && paddr[7:2] == i;
	endsequence
	sequence s_rd(logic [5:0] i);
		psel && penable && pready && !pwrite && paddr[7:2] == i;
	endsequence
	sequence s_setup;
		psel && !penable;
	endsequence
	AST_PREADY: assert property (s_setup |=> pready ##1 !pready)
		else $error("pready not a single access cycle");
	AST_ERR: assert property (
		pslverr |-> pready && (pwrite || prdata == 32'h0))
		else $error("error response malformed");
	AST_RDMASK: assert property (s_rd(6'h15) |->
		prdata[31:14] == 18'h0 && prdata[9:3] == 7'h0)
		else $error("undefined bits read nonzero");
	AST_RATIO: assert property (s_wr(6'h15) |-> ##2
		ratio_code_valid == ($past(pwdata[13:10], 2) <= 4'h9))
		else $error("ratio valid wrong");
	AST_RATIO_TOP: assert property (
		s_wr(6'h15) ##0 (pwdata[13:10] == 4'h9)
		|-> ##2 system_clock_to_fs_ratio == 11'h600)
		else $error("top ratio wrong");
	AST_RATE: assert property (s_wr(6'h15) |-> ##2
		sample_rate_code == $past(pwdata[2:0], 2) &&
		sample_rate_valid == ($past(pwdata[2:0], 2) <= 3'h5))
		else $error("sample rate wrong");
	AST_OPCLK: assert property (s_wr(6'h16) |-> ##2
		pin_output_clock_en == $past(pwdata[3], 2))
		else $error("output clock enable wrong");
	AST_OSR: assert property (s_wr(6'h0A) |-> ##2
		adc_high_oversample == $past(pwdata[0], 2))
		else $error("oversample wrong");
	AST_CONV: assert property (s_wr(6'h12) |-> ##2
		{left_dac_en, right_dac_en, left_adc_en, right_adc_en}
		== $past(pwdata[3:0], 2))
		else $error("converter enables wrong");
	AST_BIAS: assert property (s_wr(6'h07) |-> ##2
		mic_bias_level_sel ==
		($past(pwdata[2], 2) ? 3'h4 : $past(pwdata[2:0], 2)))
		else $error("bias level wrong");
	AST_SWRST: assert property (s_wr(6'h00) |-> ##2
		adc_high_oversample && !left_dac_en && !right_adc_en &&
		sample_rate_code == 3'h5 && timeout_clk_log2_scale == 4'hF &&
		mic_bias_level_sel == 3'h0)
		else $error("software reset left fields set");
endmodule

bind cpc_regs cpc_regs_asserts u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr),
	.mic_bias_level_sel(mic_bias_level_sel),
	.adc_high_oversample(adc_high_oversample),
	.left_dac_en(left_dac_en), .right_dac_en(right_dac_en),
	.left_adc_en(left_adc_en), .right_adc_en(right_adc_en),
	.system_clock_to_fs_ratio(system_clock_to_fs_ratio),
	.ratio_code_valid(ratio_code_valid),
	.sample_rate_code(sample_rate_code),
	.sample_rate_valid(sample_rate_valid),
	.timeout_clk_log2_scale(timeout_clk_log2_scale),
	.pin_output_clock_en(pin_output_clock_en)
);
`default_nettype wire

// [test/test_codec_power_clock_regs.sv]
`default_nettype none
module test_codec_power_clock_regs;
	timeunit 1ns;
	timeprecision 1ps;
	localparam [15:0] ID = 16'h3C96;  // arbitrary value
	logic        pclk, presetn, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, p;
	wire  [31:0] prdata;
	wire         pready, pslverr, osr, ratio_ok, sr_ok;
	wire         in_l, in_r, hp_l, hp_r, lo_l, lo_r, dac_l, dac_r, adc_l;
	wire         adc_r, sys_src, mck_inv, mck_half, sys_gate, to_en;
	wire         dsp_en, op_en;
	wire  [2:0]  bias, sr_code;
	wire  [10:0] ratio;
	wire  [3:0]  scale;
	wire  [40:0] obs = {in_l, in_r, hp_l, hp_r, lo_l, lo_r, dac_l, dac_r,
		adc_l, adc_r, sys_src, mck_inv, mck_half, sys_gate, to_en, dsp_en,
		op_en, bias, osr, ratio, ratio_ok, sr_code, sr_ok, scale};
	int          bad_count = 0;
	int          n_checks = 0;
	logic [5:0]  idx_t [9] = '{6'h07, 6'h0A, 6'h0C, 6'h0E, 6'h0F, 6'h12,
		6'h14, 6'h15, 6'h16};
	logic [31:0] msk_t [9] = '{32'h7, 32'h1, 32'h3, 32'h3, 32'h3, 32'hF,
		32'h6001, 32'h3C07, 32'hD00F};
	logic [31:0] rst_t [9] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0,
		32'h0, 32'h0C05, 32'h0};
	logic [31:0] pats [3] = '{32'hFFFFFFFF, 32'h00005555, 32'h0000AAAA};

	cpc_regs #(.DEVICE_ID(ID)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mic_bias_level_sel(bias),
		.adc_high_oversample(osr), .left_input_amp_en(in_l),
		.right_input_amp_en(in_r), .left_headphone_en(hp_l),
		.right_headphone_en(hp_r), .left_lineout_en(lo_l),
		.right_lineout_en(lo_r), .left_dac_en(dac_l), .right_dac_en(dac_r),
		.left_adc_en(adc_l), .right_adc_en(adc_r),
		.system_clock_source(sys_src), .master_clk_invert(mck_inv),
		.master_clk_halve(mck_half), .system_clock_gate(sys_gate),
		.system_clock_to_fs_ratio(ratio), .ratio_code_valid(ratio_ok),
		.sample_rate_code(sr_code), .sample_rate_valid(sr_ok),
		.timeout_clk_log2_scale(scale), .timeout_clock_en(to_en),
		.processing_clock_en(dsp_en), .pin_output_clock_en(op_en)
	);

	always #5 pclk = ~pclk;

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [63:0] e, g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask

	// one apb transfer, checks read data and error response
	task automatic acc(input logic [5:0] i, input logic w,
		input logic [31:0] d, x, input logic xe);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {i, 2'h0};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 16);
		chk("pready", 1'h1, pready);
		if (!w)
			chk("prdata", x, prdata);
		chk("pslverr", xe, pslverr);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	function automatic [10:0] rat(input logic [3:0] c);
		case (c)
			4'h0: rat = 11'h040;
			4'h1: rat = 11'h080;
			4'h2: rat = 11'h0C0;
			4'h3: rat = 11'h100;
			4'h4: rat = 11'h180;
			4'h5: rat = 11'h200;
			4'h6: rat = 11'h300;
			4'h7: rat = 11'h400;
			4'h8: rat = 11'h580;
			4'h9: rat = 11'h600;
			default: rat = 11'h000;
		endcase
	endfunction

	// outputs expected when every register holds q
	function automatic [40:0] exp_of(input logic [31:0] q);
		logic [3:0] s;
		s = 4'h0;
		if (q[13])
			s = s + 4'h2;
		if (q[14])
			s = s - 4'h4;
		if (!q[12])
			s = s - 4'h1;
		exp_of = {q[1:0], q[1:0], q[1:0], q[3:0], q[14], q[15], q[0], q[2],
			q[0], q[1], q[3], q[2] ? 3'h4 : q[2:0], q[0], rat(q[13:10]),
			q[13:10] <= 4'h9, q[2:0], q[2:0] <= 3'h5, s};
	endfunction

	task automatic wall(input logic [31:0] q);
		for (int k = 0; k < 9; k++)
			acc(idx_t[k], 1'h1, q, 32'h0, 1'h0);
	endtask

	task automatic vall(input logic [31:0] q);
		for (int k = 0; k < 9; k++)
			acc(idx_t[k], 1'h0, 32'h0, q & msk_t[k], 1'h0);
		#1;
		chk("outputs", exp_of(q),
			obs);
	endtask

	task automatic defaults;
		acc(6'h00, 1'h0, 32'h0, {16'h0, ID}, 1'h0);
		for (int k = 0; k < 9; k++)
			acc(idx_t[k], 1'h0, 32'h0, rst_t[k], 1'h0);
		#1;
		chk("defaults", {17'h0, 3'h0, 1'h1, 11'h100, 1'h1, 3'h5, 1'h1, 4'hF},
			obs);
	endtask

	initial begin
		pclk = 1'h0;
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		defaults();
		$display("test reset values done");
		for (int k = 0; k < 3; k++) begin
			wall(pats[k]);
			vall(pats[k]);
		end
		for (int c = 0; c < 16; c++) begin
			p = {17'h0, c[0], c[3:0], 7'h0, c[2:0]};
			wall(p);
			vall(p);
		end
		$display("test field codes done");
		acc(6'h01, 1'h0, 32'h0, 32'h0, 1'h1);
		acc(6'h13, 1'h1, 32'hFFFFFFFF, 32'h0, 1'h1);
		acc(6'h3F, 1'h0, 32'h0, 32'h0, 1'h1);
		vall(p);
		$display("test unmapped done");
		wall(32'hFFFFFFFF);
		acc(6'h00, 1'h1, 32'h00001234, 32'h0, 1'h0);
		defaults();
		$display("test software reset done");
		wall(32'hFFFFFFFF);
		@(posedge pclk);
		presetn <= 1'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		defaults();
		$display("test hardware reset done");
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
